// [qpf_host_model.sv]
// host model driving the command port of the register bank
`timescale 1ns/1ns
`default_nettype none
module qpf_host_model (
    input  wire logic       ref_clk,
    input  wire logic       cmdAck,
    input  wire logic [7:0] cmdRdData,
    output var  logic       cmdStrobe,
    output var  logic       cmdWrite,
    output var  logic [7:0] cmdCode,
    output var  logic [7:0] cmdWrData
);
    initial begin
        cmdStrobe = 1'b0;
        {cmdWrite, cmdCode, cmdWrData} = 17'h00000;
    end
    // one-cycle strobe; released lines show inverted junk, not the old byte
    task xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
              output logic [7:0] rd, output logic ack);
        @(posedge ref_clk);
        cmdStrobe <= 1'b1;
        {cmdWrite, cmdCode, cmdWrData} <= {w, c, d};
        @(posedge ref_clk);
        cmdStrobe <= 1'b0;
        {cmdWrite, cmdCode, cmdWrData} <= ~{w, c, d};
        // answer taken at the rising edge at which the ack stands
        @(posedge ref_clk);
        ack = cmdAck;
        rd = cmdRdData;
    endtask : xfer
endmodule : qpf_host_model
`default_nettype wire

// [quad_pair_fault_pkg.sv]
// constants for the quad-pair fault policy and die temperature registers
package quad_pair_fault_pkg;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_DIE_TEMPERATURE  = 8'h2C;
    localparam logic [7:0] CMD_QUAD_PAIR_FAULT  = 8'h2D;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FAULT_CFG_RESET      = 8'h00;
    localparam logic [7:0] DIE_TEMP_RESET       = 8'h00;
    localparam logic [7:0] UNMAPPED_READ        = 8'h00;

    // ------------------------------------------------------------------
    // field positions in the fault configuration byte (port 0 = ch1/2)
    // ------------------------------------------------------------------
    localparam int CURLIM_BOTH_OFF_POS    = 6;
    localparam int POWERCUT_BOTH_OFF_POS  = 4;
    localparam int SUMMED_POLICING_POS    = 2;
    localparam int DISCONNECT_SEL_POS     = 0;
    localparam int NUM_PORTS              = 2;
    localparam int NUM_CHANNELS           = 4;

    // ------------------------------------------------------------------
    // temperature code scaling: degC = OFFSET + code * STEP
    // ------------------------------------------------------------------
    localparam real TEMP_OFFSET_DEGC      = -20.0;
    localparam real TEMP_STEP_DEGC        = 0.652;
    localparam real TEMP_FULL_SCALE_DEGC  = 146.2;

    // ------------------------------------------------------------------
    // disconnect threshold levels selected by the low two bits
    // ------------------------------------------------------------------
    localparam real DISCONNECT_LOW_MA     = 4.5;
    localparam real DISCONNECT_HIGH_MA    = 6.5;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int TEMP_REFRESH_MS        = 1000;
    localparam int CLK_PERIOD_NS          = 100;
    localparam int TEMP_REFRESH_CYCLES    = TEMP_REFRESH_MS * (1000000 / CLK_PERIOD_NS);
    localparam int REFRESH_CNT_W          = 24;

endpackage : quad_pair_fault_pkg

// [quad_pair_fault_policy.sv]
// fault policy configuration and die temperature register bank
//
// Function
// - read-only 8-bit temperature, refreshed once per second
// - code maps -20 plus N times 0.652 degC
// - command 2Dh config byte, read/write, resets zero
// - current-limit bit set disables both port channels
// - power-cut bit set disables both port channels
// - auto mode sets both fault bits after turn-on
// - summed enable bit activates summed power policing
// - summed policing off when clear; current limit continues
// - auto/semi-auto set summed enable after 4-pair turn-on
// - low bits select 4.5 mA or 6.5 mA disconnect
`timescale 1ns/1ns
`default_nettype none

module quad_pair_fault_policy #(
    parameter int REFRESH_CYCLES = quad_pair_fault_pkg::TEMP_REFRESH_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // command port from the management bus decoder
    input  wire logic       cmdStrobe,
    input  wire logic       cmdWrite,
    input  wire logic [7:0] cmdCode,
    input  wire logic [7:0] cmdWrData,
    output var  logic       cmdAck,
    output var  logic [7:0] cmdRdData,
    // converter and operating mode
    input  wire logic [7:0] adcTempCode,
    input  wire logic       autoMode,
    input  wire logic       semiAutoMode,
    // per port and per channel events
    input  wire logic [1:0] singleSigPowered,
    input  wire logic [3:0] current_limit_fault,
    input  wire logic [3:0] powercutFault,
    input  wire logic [1:0] summedPowerOver,
    input  wire logic [3:0] chPowerOn,
    // results
    output var  logic [3:0] chDisabled,
    output var  logic [7:0] die_temp_code,
    output var  logic [1:0] summed_policing_enable,
    output var  logic [1:0] disconnect_threshold_select
);

    // ------------------------------------------------------------------
    // converter input synchroniser
    // ------------------------------------------------------------------
    logic [7:0] tempMeta_ff;
    logic [7:0] tempSync_ff;
    logic [7:0] tempSettled_ff;

    // the converter settles on its own timebase, so pass it two flops;
    // bits may land a cycle apart, so a third stage confirms the word
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tempMeta_ff    <= quad_pair_fault_pkg::DIE_TEMP_RESET;
            tempSync_ff    <= quad_pair_fault_pkg::DIE_TEMP_RESET;
            tempSettled_ff <= quad_pair_fault_pkg::DIE_TEMP_RESET;
        end else begin
            tempMeta_ff    <= adcTempCode;
            tempSync_ff    <= tempMeta_ff;
            tempSettled_ff <= tempSync_ff;
        end
    end

    // ------------------------------------------------------------------
    // temperature refresh
    // ------------------------------------------------------------------
    logic [quad_pair_fault_pkg::REFRESH_CNT_W-1:0] refreshCnt_ff;
    logic [quad_pair_fault_pkg::REFRESH_CNT_W-1:0] nxt_refreshCnt;
    logic [7:0]                                    dieTemp_ff;
    logic [7:0]                                    nxt_dieTemp;

    // code is kept raw; software applies -20 + N * 0.652 degC
    always_comb begin
        nxt_refreshCnt = refreshCnt_ff + 1'b1;
        nxt_dieTemp    = dieTemp_ff;
        if (refreshCnt_ff == REFRESH_CYCLES[quad_pair_fault_pkg::REFRESH_CNT_W-1:0] - 1'b1) begin
            nxt_refreshCnt = '0;
            // a word still moving keeps the old code until the next refresh
            if (tempSync_ff == tempSettled_ff) begin
                nxt_dieTemp = tempSync_ff;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            refreshCnt_ff <= '0;
            dieTemp_ff    <= quad_pair_fault_pkg::DIE_TEMP_RESET;
        end else begin
            refreshCnt_ff <= nxt_refreshCnt;
            dieTemp_ff    <= nxt_dieTemp;
        end
    end

    // ------------------------------------------------------------------
    // fault configuration register and command answers
    // ------------------------------------------------------------------
    logic [7:0] faultCfg_ff;
    logic [7:0] nxt_faultCfg;
    logic       ack_ff;
    logic       nxt_ack;
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;
    logic       hitCfg;

    assign hitCfg = cmdStrobe && (cmdCode == quad_pair_fault_pkg::CMD_QUAD_PAIR_FAULT);

    // host write first, then hardware sets so a same-cycle set wins
    always_comb begin
        nxt_faultCfg = faultCfg_ff;
        if (hitCfg && cmdWrite) begin
            nxt_faultCfg = cmdWrData;
        end
        for (int p = 0; p < quad_pair_fault_pkg::NUM_PORTS; p++) begin
            if (singleSigPowered[p] && autoMode) begin
                nxt_faultCfg[quad_pair_fault_pkg::CURLIM_BOTH_OFF_POS + p]   = 1'b1;
                nxt_faultCfg[quad_pair_fault_pkg::POWERCUT_BOTH_OFF_POS + p] = 1'b1;
            end
            if (singleSigPowered[p] && (autoMode || semiAutoMode)) begin
                nxt_faultCfg[quad_pair_fault_pkg::SUMMED_POLICING_POS + p] = 1'b1;
            end
        end
    end

    // every command is acknowledged, writes to read-only codes are dropped
    always_comb begin
        nxt_ack    = cmdStrobe;
        nxt_rdData = rdData_ff;
        if (cmdStrobe && !cmdWrite) begin
            case (cmdCode)
                quad_pair_fault_pkg::CMD_DIE_TEMPERATURE: nxt_rdData = dieTemp_ff;
                quad_pair_fault_pkg::CMD_QUAD_PAIR_FAULT: nxt_rdData = faultCfg_ff;
                default:                                  nxt_rdData = quad_pair_fault_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            faultCfg_ff <= quad_pair_fault_pkg::FAULT_CFG_RESET;
            ack_ff      <= 1'b0;
            rdData_ff   <= quad_pair_fault_pkg::UNMAPPED_READ;
        end else begin
            faultCfg_ff <= nxt_faultCfg;
            ack_ff      <= nxt_ack;
            rdData_ff   <= nxt_rdData;
        end
    end

    // ------------------------------------------------------------------
    // per-port channel disable policy
    // ------------------------------------------------------------------
    logic [3:0] chDisabled_ff;
    logic [3:0] nxt_chDisabled;

    genvar gp;
    generate
        for (gp = 0; gp < quad_pair_fault_pkg::NUM_PORTS; gp++) begin : g_port
            logic curlimBoth;
            logic powercutBoth;
            logic summedOn;
            logic summedTrip;
            logic [1:0] ownFault;
            logic [1:0] partnerFault;
            logic [1:0] nxtPair;

            assign curlimBoth   = faultCfg_ff[quad_pair_fault_pkg::CURLIM_BOTH_OFF_POS + gp];
            assign powercutBoth = faultCfg_ff[quad_pair_fault_pkg::POWERCUT_BOTH_OFF_POS + gp];
            assign summedOn     = faultCfg_ff[quad_pair_fault_pkg::SUMMED_POLICING_POS + gp];
            // summed trip only counts while policing is enabled
            assign summedTrip   = summedOn && summedPowerOver[gp];

            // current limit is always watched on the faulting channel
            assign ownFault = current_limit_fault[2*gp +: 2] | powercutFault[2*gp +: 2];

            // partner's fault spreads only when the both-off bit is set
            assign partnerFault[0] = (curlimBoth && current_limit_fault[2*gp+1])
                                   || (powercutBoth && powercutFault[2*gp+1]);
            assign partnerFault[1] = (curlimBoth && current_limit_fault[2*gp])
                                   || (powercutBoth && powercutFault[2*gp]);

            // a new fault outranks a turn-on in the same cycle
            always_comb begin
                for (int c = 0; c < 2; c++) begin
                    nxtPair[c] = chDisabled_ff[2*gp+c];
                    if (chPowerOn[2*gp+c]) begin
                        nxtPair[c] = 1'b0;
                    end
                    if (ownFault[c] || partnerFault[c] || summedTrip) begin
                        nxtPair[c] = 1'b1;
                    end
                end
            end

            // each port drives only its own slice, one writer per bit
            assign nxt_chDisabled[2*gp +: 2] = nxtPair;
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chDisabled_ff <= '0;
        end else begin
            chDisabled_ff <= nxt_chDisabled;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------------
    assign cmdAck                      = ack_ff;
    assign cmdRdData                   = rdData_ff;
    assign chDisabled                  = chDisabled_ff;
    assign die_temp_code               = dieTemp_ff;
    assign summed_policing_enable      = faultCfg_ff[quad_pair_fault_pkg::SUMMED_POLICING_POS +: 2];
    // bit high picks the lower 4.5 mA level, low picks 6.5 mA
    assign disconnect_threshold_select = faultCfg_ff[quad_pair_fault_pkg::DISCONNECT_SEL_POS +: 2];

endmodule : quad_pair_fault_policy

`default_nettype wire

// [quad_pair_fault_policy_sva.sv]
// assertion checker for the fault policy register bank
`timescale 1ns/1ns
`default_nettype none
module qpf_checker (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       cmdStrobe,
    input wire logic       cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] cmdWrData,
    input wire logic       cmdAck,
    input wire logic [7:0] cmdRdData,
    input wire logic       autoMode,
    input wire logic       semiAutoMode,
    input wire logic [1:0] singleSigPowered,
    input wire logic [3:0] current_limit_fault,
    input wire logic [3:0] powercutFault,
    input wire logic [1:0] summedPowerOver,
    input wire logic [3:0] chDisabled,
    input wire logic [1:0] summed_policing_enable,
    input wire logic [1:0] disconnect_threshold_select
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    property p_ack; cmdStrobe |=> cmdAck; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_tempWr; cmdStrobe && cmdWrite && cmdCode == 8'h2C |=> cmdAck; endproperty
    a_tempWr: assert property (p_tempWr) else $error("temp write not acked");
    property p_wr; cmdStrobe && cmdWrite && cmdCode == 8'h2D && singleSigPowered == 2'b00
        |=> {summed_policing_enable, disconnect_threshold_select} == $past(cmdWrData[3:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("config bits wrong");
    property p_rd; cmdStrobe && !cmdWrite && cmdCode == 8'h2D
        |=> cmdRdData[3:0] == $past({summed_policing_enable, disconnect_threshold_select});
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_cl; current_limit_fault[0] |=> chDisabled[0]; endproperty
    a_cl: assert property (p_cl) else $error("limit fault ignored");
    property p_pc; powercutFault[3] |=> chDisabled[3]; endproperty
    a_pc: assert property (p_pc) else $error("cut fault ignored");
    property p_sum; summedPowerOver[0] && summed_policing_enable[0] |=> &chDisabled[1:0];
    endproperty
    a_sum: assert property (p_sum) else $error("summed trip missed");
    property p_auto; (autoMode || semiAutoMode) && singleSigPowered != 2'b00
        |=> (summed_policing_enable & $past(singleSigPowered)) == $past(singleSigPowered);
    endproperty
    a_auto: assert property (p_auto) else $error("summed enable not set");
endmodule : qpf_checker
bind quad_pair_fault_policy qpf_checker chk_u (
    .ref_clk                     (ref_clk),
    .resetn                      (resetn),
    .cmdStrobe                   (cmdStrobe),
    .cmdWrite                    (cmdWrite),
    .cmdCode                     (cmdCode),
    .cmdWrData                   (cmdWrData),
    .cmdAck                      (cmdAck),
    .cmdRdData                   (cmdRdData),
    .autoMode                    (autoMode),
    .semiAutoMode                (semiAutoMode),
    .singleSigPowered            (singleSigPowered),
    .current_limit_fault         (current_limit_fault),
    .powercutFault               (powercutFault),
    .summedPowerOver             (summedPowerOver),
    .chDisabled                  (chDisabled),
    .summed_policing_enable      (summed_policing_enable),
    .disconnect_threshold_select (disconnect_threshold_select)
);
`default_nettype wire

// [testbench.sv]
// self-checking bench for the fault policy register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] QPF = quad_pair_fault_pkg::CMD_QUAD_PAIR_FAULT;
    localparam logic [7:0] TMP = quad_pair_fault_pkg::CMD_DIE_TEMPERATURE;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmdStrobe, cmdWrite, cmdAck, autoMode, semiAutoMode, ack;
    logic [7:0] cmdCode, cmdWrData, cmdRdData, adcTempCode, die_temp_code, rd, wd;
    logic [1:0] singleSigPowered, summedPowerOver;
    logic [1:0] summed_policing_enable, disconnect_threshold_select;
    logic [3:0] current_limit_fault, powercutFault, chPowerOn, chDisabled;
    logic [31:0] seed = 32'h11636C2B;
    logic [31:0] r;
    int n_errors = 0;
    int n_compared = 0;
    int cycleCount = 0;
    // fault table: config byte, kind (limit, cut, summed), index, disabled set
    logic [7:0] cfgT [6] = '{8'h40, 8'h00, 8'h20, 8'h00, 8'h04, 8'h00};
    int kindT [6] = '{0, 0, 1, 1, 2, 2};
    int idxT [6] = '{0, 0, 2, 3, 0, 0};
    logic [3:0] expT [6] = '{4'h3, 4'h1, 4'hC, 4'h8, 4'h3, 4'h0};
    quad_pair_fault_policy #(.REFRESH_CYCLES(20)) dut_u (
        .ref_clk                     (ref_clk),
        .resetn                      (resetn),
        .cmdStrobe                   (cmdStrobe),
        .cmdWrite                    (cmdWrite),
        .cmdCode                     (cmdCode),
        .cmdWrData                   (cmdWrData),
        .cmdAck                      (cmdAck),
        .cmdRdData                   (cmdRdData),
        .adcTempCode                 (adcTempCode),
        .autoMode                    (autoMode),
        .semiAutoMode                (semiAutoMode),
        .singleSigPowered            (singleSigPowered),
        .current_limit_fault         (current_limit_fault),
        .powercutFault               (powercutFault),
        .summedPowerOver             (summedPowerOver),
        .chPowerOn                   (chPowerOn),
        .chDisabled                  (chDisabled),
        .die_temp_code               (die_temp_code),
        .summed_policing_enable      (summed_policing_enable),
        .disconnect_threshold_select (disconnect_threshold_select)
    );
    qpf_host_model host_u (
        .ref_clk   (ref_clk),
        .cmdAck    (cmdAck),
        .cmdRdData (cmdRdData),
        .cmdStrobe (cmdStrobe),
        .cmdWrite  (cmdWrite),
        .cmdCode   (cmdCode),
        .cmdWrData (cmdWrData)
    );
    always #50 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task cmd(input logic w, input logic [7:0] c, input logic [7:0] d);
        host_u.xfer(w, c, d, rd, ack);
        chk("ack", 8'h01, {7'h00, ack});
    endtask : cmd
    task test_done();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 5000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        adcTempCode = 8'h00;
        {autoMode, semiAutoMode, singleSigPowered, summedPowerOver} = 6'h00;
        {current_limit_fault, powercutFault, chPowerOn} = 12'h000;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        cmd(1'b0, QPF, 8'h00);
        chk("cfg reset", quad_pair_fault_pkg::FAULT_CFG_RESET, rd);
        // random bytes, all-ones first, each read straight back
        for (int i = 0; i < 16; i++) begin
            r = xs();
            wd = (i == 0) ? 8'hFF : r[7:0];
            cmd(1'b1, QPF, wd);
            chk("policing", {6'h00, wd[3:2]}, {6'h00, summed_policing_enable});
            chk("disconnect", {6'h00, wd[1:0]}, {6'h00, disconnect_threshold_select});
            cmd(1'b0, QPF, 8'h00);
            chk("cfg", wd, rd);
        end
        // reset in mid-run must clear every configuration bit
        cmd(1'b1, QPF, 8'hFF);
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        chk("cfg out", 8'h00, {4'h0, summed_policing_enable, disconnect_threshold_select});
        cmd(1'b0, QPF, 8'h00);
        chk("cfg rerun", quad_pair_fault_pkg::FAULT_CFG_RESET, rd);
        // new converter code must land within one refresh plus sync
        r = xs();
        @(posedge ref_clk);
        adcTempCode <= r[7:0];
        repeat (24) @(posedge ref_clk);
        cmd(1'b1, TMP, ~r[7:0]);
        chk("temp out", r[7:0], die_temp_code);
        cmd(1'b0, TMP, 8'h00);
        chk("temp read", r[7:0], rd);
        cmd(1'b0, 8'h7E, 8'h00);
        chk("unmapped", quad_pair_fault_pkg::UNMAPPED_READ, rd);
        for (int i = 0; i < 6; i++) begin
            cmd(1'b1, QPF, cfgT[i]);
            @(posedge ref_clk);
            case (kindT[i])
                0: current_limit_fault[idxT[i]] <= 1'b1;
                1: powercutFault[idxT[i]] <= 1'b1;
                default: summedPowerOver[idxT[i]] <= 1'b1;
            endcase
            @(posedge ref_clk);
            {current_limit_fault, powercutFault, summedPowerOver} <= 10'h000;
            @(negedge ref_clk);
            chk("disabled", {4'h0, expT[i]}, {4'h0, chDisabled});
            @(posedge ref_clk);
            chPowerOn <= 4'hF;
            @(posedge ref_clk);
            chPowerOn <= 4'h0;
        end
        // turn-on of a single-signature device, automatic then semi-automatic
        for (int m = 0; m < 2; m++) begin
            cmd(1'b1, QPF, 8'h00);
            @(posedge ref_clk);
            {autoMode, semiAutoMode, singleSigPowered} <= (m == 0) ? 4'hA : 4'h5;
            @(posedge ref_clk);
            singleSigPowered <= 2'b00;
            cmd(1'b0, QPF, 8'h00);
            chk("auto set", (m == 0) ? 8'hA8 : 8'h04, rd);
        end
        test_done();
    end
endmodule : testbench
`default_nettype wire
